// ===== logic/dspem_monitor.sv
`timescale 1ns/1ns
module dspem_monitor
  import dspem_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              frame_start,
  input  wire logic [PC_W-1:0]   core_pc,
  output logic                   block_irq,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [PC_W-1:0] pc_max(
    input logic [PC_W-1:0] a,
    input logic [PC_W-1:0] b
  );
    pc_max = (a > b) ? a : b;
  endfunction : pc_max

  function automatic logic [DATA_W-1:0] upper_half(
    input logic [PC_W-1:0] v
  );
    upper_half = {{(DATA_W-UPPER_W){1'b0}}, v[PC_W-1:DATA_W]};
  endfunction : upper_half

  function automatic logic [DATA_W-1:0] lower_half(
    input logic [PC_W-1:0] v
  );
    lower_half = v[DATA_W-1:0];
  endfunction : lower_half

  function automatic logic [DATA_W-1:0] bit_word(
    input logic v
  );
    bit_word = {{(DATA_W-1){1'b0}}, v};
  endfunction : bit_word

  function automatic logic [DATA_W-1:0] event_word(
    input logic [EV_W-1:0] v
  );
    event_word = {{(DATA_W-EV_W){1'b0}}, v};
  endfunction : event_word

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic              block_irq_gate;
  logic [DATA_W-1:0] block_length_frames;
  logic              pc_clear_bit;
  logic [DATA_W-1:0] frame_count;
  logic [PC_W-1:0]   pc_now;
  logic [PC_W-1:0]   running_peak;
  logic [PC_W-1:0]   frame_peak;
  logic [PC_W-1:0]   alltime_peak;
  logic [EV_W-1:0]   irq_status;
  logic [EV_W-1:0]   irq_enable;

  logic              wr_gate;
  logic              wr_length;
  logic              wr_clear;
  logic              wr_irq_en;
  logic              wr_irq_clr;
  logic              clear_release;
  logic              frame_done;
  logic              block_done;
  logic              period_end;
  logic [DATA_W-1:0] count_plus;
  logic [PC_W-1:0]   peak_with_now;
  logic              new_max;
  logic [EV_W-1:0]   events;
  logic [EV_W-1:0]   next_irq_status;
  logic [EV_W-1:0]   next_irq_enable;

  // ---------------------------------------------------------------
  // register write decode
  // ---------------------------------------------------------------
  assign wr_gate    = reg_write && (reg_addr == OFF_BLOCK_INTERRUPT_ENABLE);
  assign wr_length  = reg_write && (reg_addr == OFF_BLOCK_LENGTH_FRAMES);
  assign wr_clear   = reg_write && (reg_addr == OFF_PC_CLEAR_CONTROL);
  assign wr_irq_en  = reg_write && (reg_addr == OFF_IRQ_ENABLE);
  assign wr_irq_clr = reg_write && (reg_addr == OFF_IRQ_CLEAR);

  // only the falling transition of the clear bit restarts the max
  assign clear_release = wr_clear && pc_clear_bit
                         && !reg_wdata[BIT_PC_CLEAR];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      block_irq_gate <= 1'b0;
    end else if (wr_gate) begin
      block_irq_gate <= reg_wdata[BIT_BLOCK_IRQ_GATE];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      block_length_frames <= RST_BLOCK_LENGTH;
    end else if (wr_length) begin
      block_length_frames <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pc_clear_bit <= 1'b0;
    end else if (wr_clear) begin
      pc_clear_bit <= reg_wdata[BIT_PC_CLEAR];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable <= RST_EVENTS;
    end else if (wr_irq_en) begin
      irq_enable <= reg_wdata[EV_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // block interrupt generator
  // ---------------------------------------------------------------
  assign count_plus = frame_count + 16'h0001;

  // a zero length never matches, so no block ever completes
  assign block_done = block_irq_gate && frame_start
                      && (block_length_frames != RST_BLOCK_LENGTH)
                      && (count_plus == block_length_frames);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frame_count <= RST_BLOCK_LENGTH;
    end else if (!block_irq_gate || wr_length) begin
      // idle while gated off; a new length restarts the block cleanly
      frame_count <= RST_BLOCK_LENGTH;
    end else if (block_done) begin
      frame_count <= RST_BLOCK_LENGTH;
    end else if (frame_start) begin
      frame_count <= count_plus;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      block_irq <= 1'b0;
    end else begin
      block_irq <= block_done && block_irq_gate;
    end
  end

  // ---------------------------------------------------------------
  // program counter capture
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pc_now <= RST_PC;
    end else if (pc_clear_bit) begin
      pc_now <= RST_PC;
    end else begin
      pc_now <= core_pc;
    end
  end

  // ---------------------------------------------------------------
  // peak trackers
  // ---------------------------------------------------------------
  // in block mode the peak spans a whole block, otherwise one frame
  assign frame_done    = frame_start && !block_irq_gate;
  assign period_end    = frame_done || block_done;
  assign peak_with_now = pc_max(running_peak, pc_now);
  assign new_max       = !pc_clear_bit && !clear_release
                         && (peak_with_now > alltime_peak);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      running_peak <= RST_PC;
    end else if (pc_clear_bit || period_end) begin
      running_peak <= RST_PC;
    end else begin
      running_peak <= peak_with_now;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frame_peak <= RST_PC;
    end else if (pc_clear_bit) begin
      frame_peak <= RST_PC;
    end else if (period_end) begin
      frame_peak <= peak_with_now;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alltime_peak <= RST_PC;
    end else if (clear_release) begin
      alltime_peak <= RST_PC;
    end else if (new_max) begin
      alltime_peak <= peak_with_now;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  always_comb begin
    events                    = RST_EVENTS;
    events[BIT_EV_BLOCK]      = block_done;
    events[BIT_EV_FRAME_PEAK] = period_end && !pc_clear_bit;
    events[BIT_EV_NEW_MAX]    = new_max;
    next_irq_status           = irq_status;
    if (wr_irq_clr) begin
      next_irq_status = irq_status & ~reg_wdata[EV_W-1:0];
    end
    // a new event outranks a clear landing in the same cycle
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= RST_EVENTS;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // a freshly written enable acts at once, so irq never lags the mask
  assign next_irq_enable = wr_irq_en ? reg_wdata[EV_W-1:0] : irq_enable;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & next_irq_enable);
    end
  end

  // ---------------------------------------------------------------
  // read port: data stand one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= RST_READ_DATA;
    end else if (reg_read) begin
      unique case (reg_addr)
        OFF_BLOCK_INTERRUPT_ENABLE:
          reg_rdata <= bit_word(block_irq_gate);
        OFF_BLOCK_LENGTH_FRAMES:
          reg_rdata <= block_length_frames;
        OFF_PC_NOW_HIGH:
          reg_rdata <= upper_half(pc_now);
        OFF_PC_NOW_LOW:
          reg_rdata <= lower_half(pc_now);
        OFF_PC_CLEAR_CONTROL:
          reg_rdata <= bit_word(pc_clear_bit);
        OFF_FRAME_PEAK_PC_HIGH:
          reg_rdata <= upper_half(frame_peak);
        OFF_FRAME_PEAK_PC_LOW:
          reg_rdata <= lower_half(frame_peak);
        OFF_ALLTIME_PEAK_PC_HIGH:
          reg_rdata <= upper_half(alltime_peak);
        OFF_ALLTIME_PEAK_PC_LOW:
          reg_rdata <= lower_half(alltime_peak);
        OFF_IRQ_STATUS:
          reg_rdata <= event_word(irq_status);
        OFF_IRQ_ENABLE:
          reg_rdata <= event_word(irq_enable);
        default:
          reg_rdata <= UNMAPPED_READ;
      endcase
    end else begin
      // data stand only in the cycle after a read strobe, then return to zero
      reg_rdata <= RST_READ_DATA;
    end
  end

endmodule : dspem_monitor

// ===== logic/dspem_pkg.sv
package dspem_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int PC_W   = 24;
  localparam int UPPER_W = 8;

  // ---------------------------------------------------------------
  // register offsets (word addresses on the register port)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_BLOCK_INTERRUPT_ENABLE = 16'hf450;
  localparam logic [ADDR_W-1:0] OFF_BLOCK_LENGTH_FRAMES    = 16'hf451;
  localparam logic [ADDR_W-1:0] OFF_PC_NOW_HIGH            = 16'hf460;
  localparam logic [ADDR_W-1:0] OFF_PC_NOW_LOW             = 16'hf461;
  localparam logic [ADDR_W-1:0] OFF_PC_CLEAR_CONTROL       = 16'hf462;
  localparam logic [ADDR_W-1:0] OFF_FRAME_PEAK_PC_HIGH     = 16'hf463;
  localparam logic [ADDR_W-1:0] OFF_FRAME_PEAK_PC_LOW      = 16'hf464;
  localparam logic [ADDR_W-1:0] OFF_ALLTIME_PEAK_PC_HIGH   = 16'hf465;
  localparam logic [ADDR_W-1:0] OFF_ALLTIME_PEAK_PC_LOW    = 16'hf466;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS             = 16'hf470;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE             = 16'hf471;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR              = 16'hf472;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_BLOCK_IRQ_GATE = 0;
  localparam int BIT_PC_CLEAR       = 0;
  localparam int BIT_EV_BLOCK       = 0;
  localparam int BIT_EV_FRAME_PEAK  = 1;
  localparam int BIT_EV_NEW_MAX     = 2;
  localparam int EV_W               = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_BLOCK_LENGTH = 16'h0000;
  localparam logic [DATA_W-1:0] RST_READ_DATA    = 16'h0000;
  localparam logic [PC_W-1:0]   RST_PC           = 24'h00_0000;
  localparam logic [EV_W-1:0]   RST_EVENTS       = 3'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_READ    = 16'h0000;

endpackage : dspem_pkg

// ===== verification/dspem_monitor_sva.sv
`timescale 1ns/1ns
module dspem_monitor_sva
  import dspem_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              frame_start,
  input wire logic [PC_W-1:0]   core_pc,
  input wire logic              block_irq,
  input wire logic              irq
);
  // ---------------------------------------------------------------
  // mirrors of the control registers, built from port traffic only
  // ---------------------------------------------------------------
  logic              gate_m;
  logic              clr_m;
  logic [EV_W-1:0]   ien_m;
  logic [DATA_W-1:0] len_m;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gate_m <= 1'b0;
      clr_m  <= 1'b0;
      ien_m  <= '0;
      len_m  <= 16'h0000;
    end else if (reg_write) begin
      if (reg_addr == OFF_BLOCK_INTERRUPT_ENABLE) gate_m <= reg_wdata[0];
      if (reg_addr == OFF_PC_CLEAR_CONTROL) clr_m <= reg_wdata[0];
      if (reg_addr == OFF_IRQ_ENABLE) ien_m <= reg_wdata[EV_W-1:0];
      if (reg_addr == OFF_BLOCK_LENGTH_FRAMES) len_m <= reg_wdata;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_unmapped_zero: assert property ($past(reg_read) && !($past(reg_addr)
    inside {[16'hf450:16'hf451], [16'hf460:16'hf466], [16'hf470:16'hf472]})
    |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_upper_reserved: assert property ($past(reg_read)
    && ($past(reg_addr) inside {16'hf460, 16'hf463, 16'hf465})
    |-> reg_rdata[15:8] == 8'h00)
    else $error("reserved upper bits set");
  a_block_cause: assert property (block_irq
    |-> $past(frame_start))
    else $error("block interrupt without frame");
  a_block_gated: assert property (block_irq |-> $past(gate_m))
    else $error("block interrupt while gate off");
  a_length_nonzero: assert property (block_irq
    |-> $past(len_m) != 16'h0000)
    else $error("block interrupt with zero length");
  a_pc_frozen: assert property (reg_read && clr_m
    && $past(clr_m) && (reg_addr inside {16'hf460, 16'hf461, 16'hf463,
    16'hf464}) |=> reg_rdata == 16'h0000)
    else $error("counter not held clear");
  a_irq_follow: assert property (block_irq && ien_m[0]
    && $past(ien_m[0]) |-> irq)
    else $error("enabled block event gave no irq");
  a_irq_masked: assert property (ien_m == '0 && $past(ien_m) == '0 |-> !irq)
    else $error("irq with all sources masked");
  a_pc_low_track: assert property (reg_read && !$past(clr_m)
    && reg_addr == OFF_PC_NOW_LOW |=> reg_rdata == $past(core_pc[15:0], 2))
    else $error("program counter low half wrong");
  c_block: cover property (block_irq && irq);
  c_new_max: cover property (irq && ien_m == 3'h4);
  c_clear: cover property ($fell(clr_m));
  c_peak: cover property ($past(reg_read) && reg_rdata != 16'h0000);
endmodule : dspem_monitor_sva
bind dspem_monitor dspem_monitor_sva u_sva (.clock(clock), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .frame_start(frame_start),
  .core_pc(core_pc), .block_irq(block_irq), .irq(irq));

// ===== verification/dsp_exec_monitor_blockint_test.sv
`timescale 1ns/1ns
module dsp_exec_monitor_blockint_test;
  import dspem_pkg::*;
  logic              clock = 1'b0;
  logic              reset_n = 1'b0;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic              frame_start = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [PC_W-1:0]   core_pc = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic              block_irq;
  logic              irq;
  int                n_errors = 0;
  int                cmp_count = 0;
  int                n_blk = 0;
  always #5 clock = ~clock;
  always @(posedge clock) if (block_irq === 1'b1) n_blk++;
  dspem_monitor dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .frame_start(frame_start), .core_pc(core_pc),
    .block_irq(block_irq), .irq(irq));
  // ---------------------------------------------------------------
  // shared bus and compare tasks
  // ---------------------------------------------------------------
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task rc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check($sformatf("reg %h", a), reg_rdata, exp);
  endtask : rc
  // frames spaced apart so a late block pulse is still counted
  task fr(input int n);
    repeat (n) begin
      @(posedge clock);
      frame_start <= 1'b1;
      @(posedge clock);
      frame_start <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask : fr
  task irq_is(input logic exp);
    @(posedge clock);
    #1 check("irq", irq, exp);
  endtask : irq_is
  task t_regs;
    static logic [15:0] offs [9] = '{16'hf450, 16'hf451, 16'hf460,
      16'hf461, 16'hf462, 16'hf463, 16'hf464, 16'hf465, 16'hf466};
    foreach (offs[i]) rc(offs[i], 16'h0000);
    wr(OFF_BLOCK_INTERRUPT_ENABLE, 16'hffff);
    rc(OFF_BLOCK_INTERRUPT_ENABLE, 16'h0001);
    wr(OFF_BLOCK_LENGTH_FRAMES, 16'ha5c3);
    rc(OFF_BLOCK_LENGTH_FRAMES, 16'ha5c3);
    wr(OFF_PC_NOW_LOW, 16'hffff);
    rc(OFF_PC_NOW_LOW, 16'h0000);
    rc(16'hf45f, 16'h0000);
    wr(OFF_BLOCK_INTERRUPT_ENABLE, 16'h0000);
    $display("t_regs done");
  endtask : t_regs
  task t_block;
    wr(OFF_IRQ_ENABLE, 16'h0001);
    wr(OFF_BLOCK_LENGTH_FRAMES, 16'h0003);
    n_blk = 0;
    fr(4);
    check("blocks gated", n_blk, 0);
    wr(OFF_BLOCK_INTERRUPT_ENABLE, 16'h0001);
    fr(9);
    check("blocks of 3", n_blk, 3);
    irq_is(1'b1);
    wr(OFF_IRQ_ENABLE, 16'h0000);
    irq_is(1'b0);
    wr(OFF_IRQ_ENABLE, 16'h0001);
    irq_is(1'b1);
    wr(OFF_IRQ_CLEAR, 16'h0001);
    irq_is(1'b0);
    wr(OFF_BLOCK_LENGTH_FRAMES, 16'h0001);
    n_blk = 0;
    fr(2);
    check("blocks of 1", n_blk, 2);
    wr(OFF_BLOCK_LENGTH_FRAMES, 16'h0000);
    n_blk = 0;
    fr(3);
    check("zero length", n_blk, 0);
    wr(OFF_BLOCK_INTERRUPT_ENABLE, 16'h0000);
    $display("t_block done");
  endtask : t_block
  task t_peak;
    core_pc <= 24'h12_3456;
    repeat (3) @(posedge clock);
    rc(OFF_PC_NOW_HIGH, 16'h0012);
    rc(OFF_PC_NOW_LOW, 16'h3456);
    @(posedge clock);
    core_pc <= 24'h00_0100;
    repeat (3) @(posedge clock);
    fr(2);
    rc(OFF_FRAME_PEAK_PC_HIGH, 16'h0000);
    rc(OFF_FRAME_PEAK_PC_LOW, 16'h0100);
    rc(OFF_ALLTIME_PEAK_PC_HIGH, 16'h0012);
    rc(OFF_ALLTIME_PEAK_PC_LOW, 16'h3456);
    rc(OFF_IRQ_ENABLE, 16'h0001);
    rc(OFF_IRQ_STATUS, 16'h0007);
    wr(OFF_IRQ_CLEAR, 16'h0007);
    irq_is(1'b0);
    rc(OFF_IRQ_STATUS, 16'h0000);
    rc(OFF_IRQ_CLEAR, 16'h0000);
    $display("t_peak done");
  endtask : t_peak
  task t_clear;
    wr(OFF_PC_CLEAR_CONTROL, 16'h0001);
    rc(OFF_PC_NOW_LOW, 16'h0000);
    rc(OFF_PC_CLEAR_CONTROL, 16'h0001);
    rc(OFF_FRAME_PEAK_PC_LOW, 16'h0000);
    rc(OFF_ALLTIME_PEAK_PC_LOW, 16'h3456);
    @(posedge clock);
    core_pc <= 24'h00_0000;
    wr(OFF_PC_CLEAR_CONTROL, 16'h0000);
    rc(OFF_ALLTIME_PEAK_PC_HIGH, 16'h0000);
    rc(OFF_ALLTIME_PEAK_PC_LOW, 16'h0000);
    wr(OFF_IRQ_ENABLE, 16'h0004);
    @(posedge clock);
    core_pc <= 24'h00_0200;
    repeat (4) @(posedge clock);
    rc(OFF_ALLTIME_PEAK_PC_LOW, 16'h0200);
    rc(OFF_IRQ_STATUS, 16'h0004);
    irq_is(1'b1);
    $display("t_clear done");
  endtask : t_clear
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_block();
    t_peak();
    t_clear();
    print_verdict();
  end
endmodule : dsp_exec_monitor_blockint_test
